// file: pkg/mss_pkg.sv
// Constants for the stream-out channel status register block
package mss_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int          MSS_DATA_W       = 32;
    localparam logic [7:0]  MSS_STATUS_OFS   = 8'h04;

    // ------------------------------------------------------------
    // Status field positions
    // ------------------------------------------------------------
    localparam int          MSS_HALTED_BIT   = 0;
    localparam int          MSS_IDLE_BIT     = 1;
    localparam int          MSS_RSVD_BIT     = 2;
    localparam int          MSS_ENGINE_BIT   = 3;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic        MSS_HALTED_RST   = 1'h1;
    localparam logic        MSS_IDLE_RST     = 1'h0;
    localparam logic [31:0] MSS_ZERO_WORD    = 32'h0000_0000;

    // Run/stop tracking of the channel
    typedef enum logic [1:0] {
        MSS_RUNNING,
        MSS_DRAINING,
        MSS_STOPPED
    } mss_halt_t;

endpackage : mss_pkg

// file: rtl/mss_halt_track.sv
// Run/stop tracker that raises the stopped flag once the channel is quiet
`timescale 1ns/100ps
module mss_halt_track
    import mss_pkg::*;
#(
    parameter bit DESC_MODE = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run_stop,
    input  wire logic data_busy,
    input  wire logic desc_busy,
    output logic      halted
);

    mss_halt_t state_q;
    mss_halt_t state_d;
    logic      quiet;

    // ------------------------------------------------------------
    // Quiet condition per mode
    // ------------------------------------------------------------
    always_comb begin
        if (DESC_MODE) begin
            quiet = !data_busy && !desc_busy;
        end else begin
            quiet = !data_busy;
        end
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MSS_RUNNING: begin
                if (!run_stop) begin
                    state_d = quiet ? MSS_STOPPED : MSS_DRAINING;
                end
            end
            MSS_DRAINING: begin
                if (run_stop) begin
                    state_d = MSS_RUNNING;
                end else if (quiet) begin
                    state_d = MSS_STOPPED;
                end
            end
            MSS_STOPPED: begin
                if (run_stop) begin
                    state_d = MSS_RUNNING;
                end
            end
            default: begin
                state_d = MSS_STOPPED;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= MSS_STOPPED;
        end else begin
            state_q <= state_d;
        end
    end

    assign halted = (state_q == MSS_STOPPED);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    halt_run_clear_a: assert property (@(posedge clk) disable iff (rst)
        run_stop |=> !halted)
        else $error("stopped flag set while run_stop high");

    halt_set_cause_a: assert property (@(posedge clk) disable iff (rst)
        ($rose(halted) && !$past(rst)) |-> $past(!run_stop && !data_busy && (!DESC_MODE || !desc_busy)))
        else $error("stopped flag set while channel active");

    halt_set_quiet_a: assert property (@(posedge clk) disable iff (rst)
        (!run_stop && !data_busy && (!DESC_MODE || !desc_busy)) |=> halted)
        else $error("stopped flag late after channel went quiet");

    halt_lag_a: assert property (@(posedge clk) disable iff (rst)
        (!halted && data_busy) |=> !halted)
        else $error("stopped flag set while data still moving");

endmodule : mss_halt_track

// file: rtl/mss_status_reg.sv
// Stream-out channel status register with halt, pause and write gating
//
// Behaviour
// - Status register sits at offset 04h
// - Bit 0 stopped flag, reset 1, read-only
// - Descriptor mode: stop after data, fetch cease
// - Simple mode: stop after data movement ceases
// - Stopped flag may lag run_stop clear
// - Stopped: pointer writes do not affect engine (passed while run_stop is high)
// - Stopped: byte count write starts nothing
// - Descriptor mode: paused at last descriptor
// - Simple mode: paused after transfer completes
// - Paused reads 0 while work remains (descriptor mode only; simple mode ignores DATA_BUSY)
// - Paused forced 0 while stopped
// - Simple mode: paused 0 before first transfer
// - Bit 2 reserved, reads zero
`timescale 1ns/100ps
module mss_status_reg
    import mss_pkg::*;
#(
    parameter bit DESC_MODE = 1'b1,
    parameter int ADDR_W    = 8
) (
    input  wire logic                  CLK,
    input  wire logic                  RST,
    // Register slave port
    input  wire logic                  REG_RD,
    input  wire logic                  REG_WR,
    input  wire logic [ADDR_W-1:0]     REG_ADDR,
    output logic      [MSS_DATA_W-1:0] REG_RDATA,
    output logic                       REG_RVALID,
    output logic                       REG_WACK,
    // Engine side
    input  wire logic                  RUN_STOP,
    input  wire logic                  DATA_BUSY,
    input  wire logic                  DESC_BUSY,
    input  wire logic                  DESC_AT_LAST,
    input  wire logic                  XFER_DONE,
    input  wire logic                  CUR_PTR_WR,
    input  wire logic                  LAST_PTR_WR,
    input  wire logic                  LENGTH_WR,
    output logic                       CUR_PTR_TAKE,
    output logic                       LAST_PTR_TAKE,
    output logic                       LENGTH_START,
    output logic                       RESUME,
    output logic                       HALTED,
    output logic                       IDLE
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 3 and 32");
    end

    logic                  halted;
    logic                  gate_writes;
    logic                  idle_q;
    logic                  idle_d;
    logic                  started_q;
    logic                  hold_q;
    logic                  last_take;
    logic                  len_take;
    logic                  hit_status;
    logic [MSS_DATA_W-1:0] status_word;
    logic [MSS_DATA_W-1:0] rdata_q;
    logic                  rvalid_q;
    logic                  wack_q;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        addr_hit = (a == ADDR_W'(ofs));
    endfunction : addr_hit

    // ------------------------------------------------------------
    // Halt tracking
    // ------------------------------------------------------------
    mss_halt_track #(
        .DESC_MODE (DESC_MODE)
    ) u_halt (
        .clk       (CLK),
        .rst       (RST),
        .run_stop  (RUN_STOP),
        .data_busy (DATA_BUSY),
        .desc_busy (DESC_BUSY),
        .halted    (halted)
    );

    // ------------------------------------------------------------
    // Write gating toward the engine
    // ------------------------------------------------------------
    assign gate_writes = halted && !RUN_STOP;

    always_comb begin
        if (DESC_MODE) begin
            CUR_PTR_TAKE  = CUR_PTR_WR && !gate_writes;
            last_take     = LAST_PTR_WR && !gate_writes;
            len_take      = 1'b0;
        end else begin
            CUR_PTR_TAKE  = 1'b0;
            last_take     = 1'b0;
            len_take      = LENGTH_WR && !halted;
        end
    end

    assign LAST_PTR_TAKE = last_take;
    assign LENGTH_START  = len_take;
    assign RESUME        = last_take && idle_q;

    // ------------------------------------------------------------
    // Simple mode first-transfer tracking
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RST) begin
            started_q <= 1'b0;
        end else if (len_take) begin
            started_q <= 1'b1;
        end
    end

    // Blocks re-pausing until the engine drops its at-last level
    always_ff @(posedge CLK) begin
        if (RST) begin
            hold_q <= 1'b0;
        end else if (last_take) begin
            hold_q <= 1'b1;
        end else if (!DESC_AT_LAST) begin
            hold_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Paused flag
    // ------------------------------------------------------------
    always_comb begin
        idle_d = idle_q;
        if (DESC_MODE) begin
            if (last_take) begin
                idle_d = 1'b0;
            end else if (DESC_AT_LAST && !hold_q && !DATA_BUSY && !DESC_BUSY) begin
                idle_d = 1'b1;
            end else begin
                idle_d = 1'b0;
            end
        end else begin
            if (len_take) begin
                idle_d = 1'b0;
            end else if (XFER_DONE && started_q) begin
                idle_d = 1'b1;
            end
        end
        if (halted) begin
            idle_d = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            idle_q <= MSS_IDLE_RST;
        end else begin
            idle_q <= idle_d;
        end
    end

    // ------------------------------------------------------------
    // Status word and register port
    // ------------------------------------------------------------
    always_comb begin
        status_word                 = MSS_ZERO_WORD;
        status_word[MSS_HALTED_BIT] = halted;
        status_word[MSS_IDLE_BIT]   = idle_q && !halted;
        status_word[MSS_RSVD_BIT]   = 1'b0;
        status_word[MSS_ENGINE_BIT] = DESC_MODE;
    end

    assign hit_status = addr_hit(REG_ADDR, MSS_STATUS_OFS);

    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_q <= MSS_ZERO_WORD;
        end else if (REG_RD) begin
            rdata_q <= hit_status ? status_word : MSS_ZERO_WORD;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= REG_RD;
        end
    end

    // Writes without a read in the same cycle are acknowledged; no write has an effect
    always_ff @(posedge CLK) begin
        if (RST) begin
            wack_q <= 1'b0;
        end else begin
            wack_q <= REG_WR && !REG_RD;
        end
    end

    assign REG_RDATA  = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign REG_WACK   = wack_q;
    assign HALTED     = halted;
    assign IDLE       = idle_q && !halted;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    status_read_a: assert property (@(posedge CLK) disable iff (RST)
        (REG_RD && hit_status) |=> (REG_RVALID && REG_RDATA[MSS_HALTED_BIT] == $past(halted)))
        else $error("status read at its offset returned wrong stopped bit");

    unmapped_zero_a: assert property (@(posedge CLK) disable iff (RST)
        (REG_RD && !hit_status) |=> (REG_RDATA == MSS_ZERO_WORD))
        else $error("unmapped read returned nonzero data");

    ptr_block_a: assert property (@(posedge CLK) disable iff (RST)
        (halted && !RUN_STOP && (CUR_PTR_WR || LAST_PTR_WR)) |-> !(CUR_PTR_TAKE || LAST_PTR_TAKE))
        else $error("pointer write reached engine while stopped");

    len_block_a: assert property (@(posedge CLK) disable iff (RST)
        halted |-> !LENGTH_START)
        else $error("byte count write started transfer while stopped");

    desc_pause_a: assert property (@(posedge CLK) disable iff (RST)
        (DESC_MODE && !halted && DESC_AT_LAST && !hold_q && !DATA_BUSY && !DESC_BUSY && !LAST_PTR_WR)
        |=> (idle_q || halted))
        else $error("paused flag missing at last descriptor");

    resume_clear_a: assert property (@(posedge CLK) disable iff (RST)
        (DESC_MODE && idle_q && LAST_PTR_TAKE) |-> RESUME ##1 !idle_q)
        else $error("last pointer write did not resume");

    simple_pause_a: assert property (@(posedge CLK) disable iff (RST)
        (!DESC_MODE && started_q && XFER_DONE && !LENGTH_START && !halted)
        |=> (idle_q || halted))
        else $error("paused flag missing after transfer");

    busy_not_paused_a: assert property (@(posedge CLK) disable iff (RST)
        (DESC_MODE && (DATA_BUSY || DESC_BUSY)) |=> !idle_q)
        else $error("paused while work in progress");

    halt_not_paused_a: assert property (@(posedge CLK) disable iff (RST)
        REG_RVALID |-> !(REG_RDATA[MSS_HALTED_BIT] && REG_RDATA[MSS_IDLE_BIT]))
        else $error("stopped and paused read together");

    first_xfer_a: assert property (@(posedge CLK) disable iff (RST)
        (!DESC_MODE && !started_q) |-> !IDLE)
        else $error("paused before first transfer");

    fixed_bits_a: assert property (@(posedge CLK) disable iff (RST)
        REG_RVALID |-> (REG_RDATA[MSS_RSVD_BIT] == 1'b0
            && REG_RDATA[MSS_DATA_W-1:MSS_ENGINE_BIT+1] == '0))
        else $error("reserved status bits nonzero");

    engine_bit_a: assert property (@(posedge CLK) disable iff (RST)
        (REG_RD && hit_status) |=> (REG_RDATA[MSS_ENGINE_BIT] == DESC_MODE))
        else $error("engine present bit wrong");

    write_ignored_a: assert property (@(posedge CLK) disable iff (RST)
        (REG_WR && !REG_RD) |=> (REG_WACK && $stable(REG_RDATA)))
        else $error("write to status had an effect");

    reset_state_a: assert property (@(posedge CLK)
        $past(RST) |-> (HALTED && !IDLE && !REG_RVALID && !REG_WACK && REG_RDATA == MSS_ZERO_WORD))
        else $error("outputs not at reset values after reset");

    hold_block_a: assert property (@(posedge CLK) disable iff (RST)
        (DESC_MODE && hold_q) |=> !idle_q)
        else $error("paused again before engine left last descriptor");

    ptr_pass_a: assert property (@(posedge CLK) disable iff (RST)
        (DESC_MODE && !(halted && !RUN_STOP)) |-> (CUR_PTR_TAKE == CUR_PTR_WR && LAST_PTR_TAKE == LAST_PTR_WR))
        else $error("pointer write blocked while channel not stopped");

    mode_block_a: assert property (@(posedge CLK) disable iff (RST)
        !DESC_MODE |-> !(CUR_PTR_TAKE || LAST_PTR_TAKE || RESUME))
        else $error("pointer write passed in simple mode");

    len_mode_a: assert property (@(posedge CLK) disable iff (RST)
        DESC_MODE |-> !LENGTH_START)
        else $error("byte count start in descriptor mode");

    len_pass_a: assert property (@(posedge CLK) disable iff (RST)
        (!DESC_MODE && LENGTH_WR && !halted) |-> LENGTH_START)
        else $error("byte count write blocked while running");

    len_clear_a: assert property (@(posedge CLK) disable iff (RST)
        (!DESC_MODE && LENGTH_START) |=> !IDLE)
        else $error("paused flag kept after new transfer start");

    pause_keep_a: assert property (@(posedge CLK) disable iff (RST)
        (!DESC_MODE && IDLE && !LENGTH_START) |=> (IDLE || HALTED))
        else $error("simple mode paused flag dropped without cause");

    idle_read_a: assert property (@(posedge CLK) disable iff (RST)
        (REG_RD && hit_status) |=> (REG_RDATA[MSS_IDLE_BIT] == $past(IDLE)))
        else $error("status read returned wrong paused bit");

endmodule : mss_status_reg

// file: verif/testbench.sv
// Self-checking bench for the stream-out status register in both build modes
`timescale 1ns/100ps
`define CHK(nm, ex, ac) begin checks++; if ((ac) !== (ex)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, ex, ac); end end
module testbench;
    import mss_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and outputs
    // ------------------------------------------------------------
    logic        CLK      = 1'h0;
    logic        RST      = 1'h1;
    logic [9:0]  drv      = 10'h000;
    logic [7:0]  REG_ADDR = 8'h00;
    wire         RUN_STOP, DATA_BUSY, DESC_BUSY, DESC_AT_LAST, XFER_DONE;
    wire         CUR_PTR_WR, LAST_PTR_WR, LENGTH_WR, REG_RD, REG_WR;
    logic [31:0] rdata [2];
    logic [1:0]  rvalid, wack, cur_take, last_take, len_start, resume, halted, idle;
    int          checks, err_total;
    bit          m_halt [2] = '{1'h1, 1'h1};
    bit          m_idle [2], m_blk [2], m_start [2], m_rv [2], m_wk [2];
    logic [31:0] m_rd [2] = '{32'h0, 32'h0};

    assign {RUN_STOP, DATA_BUSY, DESC_BUSY, DESC_AT_LAST, XFER_DONE,
            CUR_PTR_WR, LAST_PTR_WR, LENGTH_WR, REG_RD, REG_WR} = drv;

    always #20 CLK = ~CLK;

    // Instance 0 has the descriptor engine, instance 1 is simple mode
    for (genvar g = 0; g < 2; g++) begin : g_mode
        mss_status_reg #(.DESC_MODE(g == 0), .ADDR_W(8)) mss_status_reg_inst (
            .CLK(CLK), .RST(RST), .REG_RD(REG_RD), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR),
            .REG_RDATA(rdata[g]), .REG_RVALID(rvalid[g]), .REG_WACK(wack[g]),
            .RUN_STOP(RUN_STOP), .DATA_BUSY(DATA_BUSY), .DESC_BUSY(DESC_BUSY),
            .DESC_AT_LAST(DESC_AT_LAST), .XFER_DONE(XFER_DONE), .CUR_PTR_WR(CUR_PTR_WR),
            .LAST_PTR_WR(LAST_PTR_WR), .LENGTH_WR(LENGTH_WR), .CUR_PTR_TAKE(cur_take[g]),
            .LAST_PTR_TAKE(last_take[g]), .LENGTH_START(len_start[g]), .RESUME(resume[g]),
            .HALTED(halted[g]), .IDLE(idle[g]));
    end

    // ------------------------------------------------------------
    // Reference model, sees inputs from before the edge
    // ------------------------------------------------------------
    always @(posedge CLK) begin
        for (int m = 0; m < 2; m++) begin
            automatic bit d   = (m == 0);
            automatic bit bsy = DATA_BUSY || DESC_BUSY;
            automatic bit lt  = LAST_PTR_WR && d && !(m_halt[m] && !RUN_STOP);
            automatic bit ls  = LENGTH_WR && !d && !m_halt[m];
            if (RST) begin
                m_halt[m] = 1'h1;
                m_idle[m] = 1'h0;
                m_blk[m] = 1'h0;
                m_start[m] = 1'h0;
                m_rd[m] = 32'h0;
                m_rv[m] = 1'h0;
                m_wk[m] = 1'h0;
            end else begin
                m_rv[m] = REG_RD;
                m_wk[m] = REG_WR && !REG_RD;
                if (REG_RD) begin
                    m_rd[m] = (REG_ADDR == MSS_STATUS_OFS) ?
                              {28'h0, d, 1'h0, m_idle[m] && !m_halt[m], m_halt[m]} : 32'h0;
                end
                if (d) begin
                    if (lt) m_idle[m] = 1'h0;
                    else if (DESC_AT_LAST && !bsy && !m_blk[m]) m_idle[m] = 1'h1;
                    else m_idle[m] = 1'h0;
                    if (lt) m_blk[m] = 1'h1;
                    else if (!DESC_AT_LAST) m_blk[m] = 1'h0;
                end else if (ls) begin
                    m_idle[m] = 1'h0;
                    m_start[m] = 1'h1;
                end else if (XFER_DONE && m_start[m]) begin
                    m_idle[m] = 1'h1;
                end
                if (m_halt[m]) m_idle[m] = 1'h0;
                if (RUN_STOP) m_halt[m] = 1'h0;
                else if (!DATA_BUSY && (!d || !DESC_BUSY)) m_halt[m] = 1'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Comparison at every cycle, away from the launching edge
    // ------------------------------------------------------------
    always @(negedge CLK) begin
        for (int m = 0; m < 2; m++) begin
            automatic bit d    = (m == 0);
            automatic bit gate = !(m_halt[m] && !RUN_STOP);
            `CHK("HALTED", m_halt[m], halted[m])
            `CHK("IDLE", m_idle[m] && !m_halt[m], idle[m])
            `CHK("CUR_PTR_TAKE", CUR_PTR_WR && d && gate, cur_take[m])
            `CHK("LAST_PTR_TAKE", LAST_PTR_WR && d && gate, last_take[m])
            `CHK("LENGTH_START", LENGTH_WR && !d && !m_halt[m], len_start[m])
            `CHK("RESUME", LAST_PTR_WR && d && gate && m_idle[m], resume[m])
            `CHK("REG_RDATA", m_rd[m], rdata[m])
            `CHK("REG_RVALID", m_rv[m], rvalid[m])
            `CHK("REG_WACK", m_wk[m], wack[m])
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task step(input logic [9:0] v, input logic [7:0] a, input int n);
        repeat (n) begin
            @(posedge CLK);
            drv <= v;
            REG_ADDR <= a;
        end
    endtask : step

    task final_report;
        $display("Checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        #800000;
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [9:0] v;
        void'($urandom(40764));
        repeat (2) @(posedge CLK);
        RST <= 1'h0;
        step(10'h002, 8'h04, 1); // status after reset
        step(10'h002, 8'h00, 1); // unmapped offset
        step(10'h001, 8'h04, 1); // write to read-only status
        step(10'h003, 8'h04, 1); // read and write together
        step(10'h01C, 8'h00, 1); // pointer and length writes while stopped
        step(10'h300, 8'h00, 3); // running with data busy
        step(10'h100, 8'h00, 3); // stop asked, data still moving
        step(10'h082, 8'h04, 2); // fetch still busy in descriptor mode
        step(10'h000, 8'h04, 1);
        step(10'h200, 8'h00, 2);
        step(10'h220, 8'h00, 1); // completion before any start
        step(10'h204, 8'h00, 1); // start a transfer
        step(10'h300, 8'h00, 2);
        step(10'h220, 8'h00, 1); // transfer completes
        step(10'h240, 8'h00, 2); // engine at last descriptor
        step(10'h242, 8'h04, 1);
        step(10'h248, 8'h00, 1); // last pointer write resumes
        step(10'h240, 8'h00, 3);
        step(10'h200, 8'h00, 1);
        step(10'h240, 8'h00, 2);
        step(10'h250, 8'h00, 1);
        step(10'h040, 8'h04, 2); // stop while paused
        step(10'h04A, 8'h04, 1); // last pointer write while stopped
        step(10'h204, 8'h00, 1);
        for (int i = 0; i < 3000; i++) begin
            @(posedge CLK);
            v = 10'($urandom);
            v[9] = ($urandom_range(7) == 0) ? !drv[9] : drv[9];
            drv <= v;
            REG_ADDR <= ($urandom_range(1) == 1) ? 8'h04 : 8'($urandom);
            RST <= (i == 1500) ? 1'h1 : 1'h0;
        end
        step(10'h000, 8'h00, 2);
        final_report();
    end
endmodule : testbench
